// *** dmr_pkg.sv ***
// package: register map, field layout and constants of the five-channel transfer controller
package dmr_pkg;
   localparam int NUM_CH        = 5;
   localparam int CNT_W         = 16;
   localparam int ADDR_W        = 32;
   localparam int SRC_W         = 8;
   // register bus offsets (byte addresses, one word per register)
   localparam logic [7:0] OFS_STATUS  = 8'h00;
   localparam logic [7:0] OFS_FCLR    = 8'h04;
   localparam logic [7:0] OFS_FSET    = 8'h08;
   localparam logic [7:0] OFS_REMAP   = 8'h0C;
   localparam logic [7:0] OFS_CH_BASE = 8'h10;
   localparam logic [7:0] OFS_CH_STEP = 8'h10;
   localparam logic [7:0] OFS_CFG     = 8'h00;
   localparam logic [7:0] OFS_CNT     = 8'h04;
   localparam logic [7:0] OFS_PADDR   = 8'h08;
   localparam logic [7:0] OFS_MADDR   = 8'h0C;
   // per-channel config field positions
   localparam int CFG_EN    = 0;
   localparam int CFG_HTIE  = 1;
   localparam int CFG_TCIE  = 2;
   localparam int CFG_TEIE  = 3;
   localparam int CFG_DIR   = 4;
   localparam int CFG_CIRC  = 5;
   localparam int CFG_PINC  = 6;
   localparam int CFG_MINC  = 7;
   localparam int CFG_PRI   = 12;
   localparam int CFG_M2M   = 14;
   localparam int CFG_SRC   = 16;
   localparam int CFG_W     = 24;
   localparam logic [CFG_W-1:0] CFG_RST = 24'h000000;
   // status layout: 4 bits per channel, global/half/complete/error
   localparam int FLG_GL = 0;
   localparam int FLG_HT = 1;
   localparam int FLG_TC = 2;
   localparam int FLG_TE = 3;
   localparam logic [1:0] PRI_LOW     = 2'h0;
   localparam logic [1:0] PRI_HIGHEST = 2'h3;
   // idle cycles after each item before the next grant
   localparam logic [1:0] ACK_HOLD    = 2'h2;
   // fixed routing of request sources (index into per-channel source vector)
   localparam int SRC_SPI  = 0;
   localparam int SRC_I2C  = 1;
   localparam int SRC_TMR  = 2;
   localparam int SRC_REMP = 3;
   localparam int SRC_MISC = 4;
   // remap bit positions in the system remap config register
   localparam int RMP_ADC   = 0;
   localparam int RMP_UART  = 1;
   localparam int RMP_TMR16 = 2;
   localparam int RMP_TMR17 = 3;
   typedef enum logic [1:0] {
      DMR_IDLE  = 2'b00,
      DMR_READ  = 2'b01,
      DMR_WRITE = 2'b11,
      DMR_DONE  = 2'b10
   } dmr_state_t;
endpackage

// *** dmr_arbiter.sv ***
// file: two-stage priority arbiter, software level then lowest channel number
`timescale 1ns/1ps
module dmr_arbiter (
   input  wire logic [4:0]  req,        // pending channel requests
   input  wire logic [9:0]  level,      // two bits of software level per channel
   output logic      [4:0]  grant       // one-hot winner
);
   logic [4:0] best_mask;
   logic [1:0] top;
   always_comb begin
      top = dmr_pkg::PRI_LOW;
      for (int i = 0; i < dmr_pkg::NUM_CH; i++) begin
         if (req[i] && level[2*i +: 2] > top) begin
            top = level[2*i +: 2];
         end
      end
      for (int i = 0; i < dmr_pkg::NUM_CH; i++) begin
         best_mask[i] = req[i] && (level[2*i +: 2] == top);
      end
      grant = 5'h00;
      for (int i = dmr_pkg::NUM_CH - 1; i >= 0; i--) begin
         if (best_mask[i]) begin
            grant = 5'h00;
            grant[i] = 1'b1;
         end
      end
   end
endmodule // dmr_arbiter

// *** dmr_router.sv ***
// file: fixed and remappable request routing of peripheral request lines onto channels
`timescale 1ns/1ps
module dmr_router (
   input  wire logic       serial_unit_a_receive_request,     // first serial unit receive
   input  wire logic       serial_unit_a_transmit_request,    // first serial unit transmit
   input  wire logic       serial_unit_b_receive_request,     // second serial unit receive
   input  wire logic       serial_unit_b_transmit_request,    // second serial unit transmit
   input  wire logic       two_wire_unit_a_transmit_request,  // first two-wire transmit
   input  wire logic       two_wire_unit_a_receive_request,   // first two-wire receive
   input  wire logic       two_wire_unit_b_transmit_request,  // second two-wire transmit
   input  wire logic       two_wire_unit_b_receive_request,   // second two-wire receive
   input  wire logic [3:0] tmr_req,          // timer lines to ch2..ch5
   input  wire logic       conv_req,         // converter request
   input  wire logic       uart_tx_req,      // first async unit transmit
   input  wire logic       uart_rx_req,      // first async unit receive
   input  wire logic       tmr16_req,        // timer 16 request
   input  wire logic       tmr17_req,        // timer 17 request
   input  wire logic [3:0] system_remap_config, // remap selects
   output logic      [39:0] src_req          // 8 sources per channel
);
   logic r_adc, r_uart, r_t16, r_t17;
   assign r_adc  = system_remap_config[dmr_pkg::RMP_ADC];
   assign r_uart = system_remap_config[dmr_pkg::RMP_UART];
   assign r_t16  = system_remap_config[dmr_pkg::RMP_TMR16];
   assign r_t17  = system_remap_config[dmr_pkg::RMP_TMR17];
   always_comb begin
      src_req = 40'h0;
      // channel 1
      src_req[0*8 + dmr_pkg::SRC_REMP] = conv_req & ~r_adc;
      src_req[0*8 + dmr_pkg::SRC_MISC] = tmr17_req & ~r_t17;
      // channel 2
      src_req[1*8 + dmr_pkg::SRC_SPI]  = serial_unit_a_receive_request;
      src_req[1*8 + dmr_pkg::SRC_I2C]  = two_wire_unit_a_transmit_request;
      src_req[1*8 + dmr_pkg::SRC_TMR]  = tmr_req[0];
      src_req[1*8 + dmr_pkg::SRC_REMP] = (conv_req & r_adc) | (uart_tx_req & ~r_uart);
      src_req[1*8 + dmr_pkg::SRC_MISC] = tmr17_req & r_t17;
      // channel 3
      src_req[2*8 + dmr_pkg::SRC_SPI]  = serial_unit_a_transmit_request;
      src_req[2*8 + dmr_pkg::SRC_I2C]  = two_wire_unit_a_receive_request;
      src_req[2*8 + dmr_pkg::SRC_TMR]  = tmr_req[1];
      src_req[2*8 + dmr_pkg::SRC_REMP] = uart_rx_req & ~r_uart;
      src_req[2*8 + dmr_pkg::SRC_MISC] = tmr16_req & ~r_t16;
      // channel 4
      src_req[3*8 + dmr_pkg::SRC_SPI]  = serial_unit_b_receive_request;
      src_req[3*8 + dmr_pkg::SRC_I2C]  = two_wire_unit_b_transmit_request;
      src_req[3*8 + dmr_pkg::SRC_TMR]  = tmr_req[2];
      src_req[3*8 + dmr_pkg::SRC_REMP] = uart_tx_req & r_uart;
      src_req[3*8 + dmr_pkg::SRC_MISC] = tmr16_req & r_t16;
      // channel 5
      src_req[4*8 + dmr_pkg::SRC_SPI]  = serial_unit_b_transmit_request;
      src_req[4*8 + dmr_pkg::SRC_I2C]  = two_wire_unit_b_receive_request;
      src_req[4*8 + dmr_pkg::SRC_TMR]  = tmr_req[3];
      src_req[4*8 + dmr_pkg::SRC_REMP] = uart_rx_req & r_uart;
   end
endmodule // dmr_router

// *** dmr_top.sv ***
// file: five-channel transfer controller with routing, arbitration and event flags
// Overview of operation
// - five independent channels, each with config, request input and status
// - each channel services one selected request source at a time
// - arbiter picks by software level first, fixed hardware order second
// - directions: peripheral to memory, memory to peripheral, memory to memory
// - programmable item count up to 65535 per transfer
// - half, complete and error flags per channel, each with its own interrupt
// - software can set each event flag to raise its interrupt
// - circular option restarts the transfer instead of stopping
// - channels 2 to 5 have dedicated hardware request inputs; channel 1 has only remappable sources
// - serial and two-wire units routed to fixed channels 2 to 5
// - remappable sources follow the system remap bits
// - equal level: lowest channel number wins; four software levels
// - circular: count and both addresses reload at zero, then continue
`timescale 1ns/1ps
module dmr_top (
   input  wire logic        sys_clk,       // 25 MHz clock
   input  wire logic        sys_rst,       // async reset, active high
   input  wire logic [7:0]  reg_addr,      // register byte address
   input  wire logic [31:0] reg_wdata,     // register write data
   input  wire logic        reg_wr,        // write strobe
   input  wire logic        reg_rd,        // read strobe
   output logic      [31:0] reg_rdata,     // read data, cycle after strobe
   input  wire logic        serial_unit_a_receive_request,     // pin request
   input  wire logic        serial_unit_a_transmit_request,    // pin request
   input  wire logic        serial_unit_b_receive_request,     // pin request
   input  wire logic        serial_unit_b_transmit_request,    // pin request
   input  wire logic        two_wire_unit_a_transmit_request,  // pin request
   input  wire logic        two_wire_unit_a_receive_request,   // pin request
   input  wire logic        two_wire_unit_b_transmit_request,  // pin request
   input  wire logic        two_wire_unit_b_receive_request,   // pin request
   input  wire logic [3:0]  tmr_req,       // timer requests ch2..ch5
   input  wire logic        conv_req,      // converter request
   input  wire logic        uart_tx_req,   // async unit transmit request
   input  wire logic        uart_rx_req,   // async unit receive request
   input  wire logic        tmr16_req,     // timer 16 request
   input  wire logic        tmr17_req,     // timer 17 request
   output logic      [4:0]  req_ack,       // per-channel acknowledge pulse
   output logic      [31:0] bus_addr,      // system bus address
   output logic      [31:0] bus_wdata,     // system bus write data
   output logic             bus_rd,        // bus read strobe
   output logic             bus_wr,        // bus write strobe
   input  wire logic [31:0] bus_rdata,     // read data, in the bus_rd cycle
   input  wire logic        bus_err,       // error, beside bus_rd/bus_wr
   output logic      [4:0]  irq_ht,        // half transfer interrupt lines
   output logic      [4:0]  irq_tc,        // complete interrupt lines
   output logic      [4:0]  irq_te         // error interrupt lines
);
   localparam int N = dmr_pkg::NUM_CH;

   // synchronise every pin request: two flops before any logic
   logic [21:0] pin_raw, pin_s1_reg, pin_s2_reg;
   assign pin_raw = {serial_unit_a_receive_request, serial_unit_a_transmit_request,
                     serial_unit_b_receive_request, serial_unit_b_transmit_request,
                     two_wire_unit_a_transmit_request, two_wire_unit_a_receive_request,
                     two_wire_unit_b_transmit_request, two_wire_unit_b_receive_request,
                     tmr_req, conv_req, uart_tx_req, uart_rx_req, tmr16_req, tmr17_req,
                     5'h00};
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_reg <= 22'h0;
         pin_s2_reg <= 22'h0;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   logic [3:0]  remap_reg;
   logic [39:0] src_req;
   dmr_router u_router (
      .serial_unit_a_receive_request    (pin_s2_reg[21]),
      .serial_unit_a_transmit_request   (pin_s2_reg[20]),
      .serial_unit_b_receive_request    (pin_s2_reg[19]),
      .serial_unit_b_transmit_request   (pin_s2_reg[18]),
      .two_wire_unit_a_transmit_request (pin_s2_reg[17]),
      .two_wire_unit_a_receive_request  (pin_s2_reg[16]),
      .two_wire_unit_b_transmit_request (pin_s2_reg[15]),
      .two_wire_unit_b_receive_request  (pin_s2_reg[14]),
      .tmr_req                          (pin_s2_reg[13:10]),
      .conv_req                         (pin_s2_reg[9]),
      .uart_tx_req                      (pin_s2_reg[8]),
      .uart_rx_req                      (pin_s2_reg[7]),
      .tmr16_req                        (pin_s2_reg[6]),
      .tmr17_req                        (pin_s2_reg[5]),
      .system_remap_config              (remap_reg),
      .src_req                          (src_req)
   );

   // per-channel state
   logic [dmr_pkg::CFG_W-1:0]  cfg_reg   [N];
   logic [dmr_pkg::CNT_W-1:0]  cnt_init_reg [N];
   logic [dmr_pkg::CNT_W-1:0]  cnt_reg   [N];
   logic [31:0]                pbase_reg [N];
   logic [31:0]                mbase_reg [N];
   logic [31:0]                pptr_reg  [N];
   logic [31:0]                mptr_reg  [N];
   logic [3:0]                 flag_reg  [N];

   logic [N-1:0] ch_req, grant, ch_wr, ch_hit, ht_v, tc_v, te_v;
   logic [9:0]   lvl;
   logic [3:0]   sub;
   logic [2:0]   ch_idx;
   assign sub    = reg_addr[3:0];
   assign ch_idx = 3'(({1'b0, reg_addr[7:4]} - 5'h01));

   // request per channel: the selected source only, or free-running in memory mode
   generate
      for (genvar c = 0; c < N; c++) begin : g_req
         logic [2:0] sel;
         assign sel = cfg_reg[c][dmr_pkg::CFG_SRC +: 3];
         assign ch_req[c] = cfg_reg[c][dmr_pkg::CFG_EN] && (cnt_reg[c] != 16'h0000) &&
                            (cfg_reg[c][dmr_pkg::CFG_M2M] || src_req[c*8 + 32'(sel)]);
         assign lvl[2*c +: 2] = cfg_reg[c][dmr_pkg::CFG_PRI +: 2];
         assign ch_hit[c] = (reg_addr[7:4] == 4'(c + 1));
         assign ch_wr[c]  = reg_wr && ch_hit[c];
         assign ht_v[c] = flag_reg[c][dmr_pkg::FLG_HT] & cfg_reg[c][dmr_pkg::CFG_HTIE];
         assign tc_v[c] = flag_reg[c][dmr_pkg::FLG_TC] & cfg_reg[c][dmr_pkg::CFG_TCIE];
         assign te_v[c] = flag_reg[c][dmr_pkg::FLG_TE] & cfg_reg[c][dmr_pkg::CFG_TEIE];
      end
   endgenerate

   dmr_arbiter u_arb (
      .req   (ch_req),
      .level (lvl),
      .grant (grant)
   );

   // transfer engine
   dmr_pkg::dmr_state_t st_reg;
   logic [2:0]  cur_reg;
   logic [1:0]  hold_reg;
   logic [31:0] data_reg;
   logic        item_done, item_err;
   logic [2:0]  gnum;
   always_comb begin
      gnum = 3'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (grant[i]) begin
            gnum = 3'(i);
         end
      end
   end
   logic dir_m2p;
   assign dir_m2p  = cfg_reg[cur_reg][dmr_pkg::CFG_DIR];
   assign item_done = (st_reg == dmr_pkg::DMR_WRITE) && !bus_err;
   assign item_err  = (st_reg == dmr_pkg::DMR_READ || st_reg == dmr_pkg::DMR_WRITE) && bus_err;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg    <= dmr_pkg::DMR_IDLE;
         cur_reg   <= 3'h0;
         data_reg  <= 32'h0;
         bus_addr  <= 32'h0;
         bus_wdata <= 32'h0;
         bus_rd    <= 1'b0;
         bus_wr    <= 1'b0;
         req_ack   <= 5'h00;
         hold_reg  <= 2'h0;
      end else begin
         bus_rd  <= 1'b0;
         bus_wr  <= 1'b0;
         req_ack <= 5'h00;
         case (st_reg)
            dmr_pkg::DMR_IDLE: begin
               if (hold_reg != 2'h0) begin
                  hold_reg <= hold_reg - 2'h1;
               end else if (grant != 5'h00) begin
                  cur_reg  <= gnum;
                  bus_rd   <= 1'b1;
                  bus_addr <= cfg_reg[gnum][dmr_pkg::CFG_DIR] ? mptr_reg[gnum] : pptr_reg[gnum];
                  st_reg   <= dmr_pkg::DMR_READ;
               end
            end
            dmr_pkg::DMR_READ: begin
               if (bus_err) begin
                  st_reg <= dmr_pkg::DMR_DONE;
               end else begin
                  bus_wr    <= 1'b1;
                  bus_wdata <= bus_rdata;
                  data_reg  <= bus_rdata;
                  bus_addr  <= dir_m2p ? pptr_reg[cur_reg] : mptr_reg[cur_reg];
                  st_reg    <= dmr_pkg::DMR_WRITE;
               end
            end
            dmr_pkg::DMR_WRITE: begin
               // acknowledge only once the item has moved; the source then drops its line
               req_ack[cur_reg] <= ~cfg_reg[cur_reg][dmr_pkg::CFG_M2M] & ~bus_err;
               st_reg <= dmr_pkg::DMR_DONE;
            end
            dmr_pkg::DMR_DONE: begin
               // the dropped request needs these idle cycles to clear both sync flops
               hold_reg <= dmr_pkg::ACK_HOLD;
               st_reg   <= dmr_pkg::DMR_IDLE;
            end
            default: st_reg <= dmr_pkg::DMR_IDLE;
         endcase
      end
   end

   // per-channel registers, counters and flags
   generate
      for (genvar c = 0; c < N; c++) begin : g_ch
         logic busy_here, done_here, err_here, wrap, half_hit;
         logic [15:0] cnt_dec;
         assign busy_here = (cur_reg == 3'(c));
         assign done_here = item_done && busy_here;
         assign err_here  = item_err && busy_here;
         assign cnt_dec   = cnt_reg[c] - 16'h0001;
         assign wrap      = done_here && (cnt_dec == 16'h0000);
         assign half_hit  = done_here && (cnt_dec == (cnt_init_reg[c] >> 1));
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               cfg_reg[c]      <= dmr_pkg::CFG_RST;
               cnt_init_reg[c] <= 16'h0000;
               cnt_reg[c]      <= 16'h0000;
               pbase_reg[c]    <= 32'h0;
               mbase_reg[c]    <= 32'h0;
               pptr_reg[c]     <= 32'h0;
               mptr_reg[c]     <= 32'h0;
               flag_reg[c]     <= 4'h0;
            end else begin
               if (ch_wr[c] && sub == dmr_pkg::OFS_CFG[3:0]) begin
                  cfg_reg[c] <= reg_wdata[dmr_pkg::CFG_W-1:0];
               end
               if (err_here) begin
                  cfg_reg[c][dmr_pkg::CFG_EN] <= 1'b0;
               end
               // count and addresses only writable while the channel is off
               if (ch_wr[c] && !cfg_reg[c][dmr_pkg::CFG_EN]) begin
                  if (sub == dmr_pkg::OFS_CNT[3:0]) begin
                     cnt_init_reg[c] <= reg_wdata[15:0];
                     cnt_reg[c]      <= reg_wdata[15:0];
                  end
                  if (sub == dmr_pkg::OFS_PADDR[3:0]) begin
                     pbase_reg[c] <= reg_wdata;
                     pptr_reg[c]  <= reg_wdata;
                  end
                  if (sub == dmr_pkg::OFS_MADDR[3:0]) begin
                     mbase_reg[c] <= reg_wdata;
                     mptr_reg[c]  <= reg_wdata;
                  end
               end
               if (done_here) begin
                  if (wrap && cfg_reg[c][dmr_pkg::CFG_CIRC]) begin
                     cnt_reg[c]  <= cnt_init_reg[c];
                     pptr_reg[c] <= pbase_reg[c];
                     mptr_reg[c] <= mbase_reg[c];
                  end else begin
                     cnt_reg[c] <= cnt_dec;
                     if (cfg_reg[c][dmr_pkg::CFG_PINC]) pptr_reg[c] <= pptr_reg[c] + 32'h4;
                     if (cfg_reg[c][dmr_pkg::CFG_MINC]) mptr_reg[c] <= mptr_reg[c] + 32'h4;
                  end
               end
               // clear by write-one, then software set, then hardware set: sets win
               if (reg_wr && reg_addr == dmr_pkg::OFS_FCLR) begin
                  flag_reg[c] <= flag_reg[c] & ~reg_wdata[4*c +: 4];
               end
               if (reg_wr && reg_addr == dmr_pkg::OFS_FSET) begin
                  flag_reg[c][3:1] <= flag_reg[c][3:1] | reg_wdata[4*c+1 +: 3];
                  flag_reg[c][0]   <= flag_reg[c][0] | (|reg_wdata[4*c+1 +: 3]);
               end
               if (half_hit) begin
                  flag_reg[c][dmr_pkg::FLG_HT] <= 1'b1;
                  flag_reg[c][dmr_pkg::FLG_GL] <= 1'b1;
               end
               if (wrap) begin
                  flag_reg[c][dmr_pkg::FLG_TC] <= 1'b1;
                  flag_reg[c][dmr_pkg::FLG_GL] <= 1'b1;
               end
               if (err_here) begin
                  flag_reg[c][dmr_pkg::FLG_TE] <= 1'b1;
                  flag_reg[c][dmr_pkg::FLG_GL] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         remap_reg <= 4'h0;
      end else if (reg_wr && reg_addr == dmr_pkg::OFS_REMAP) begin
         remap_reg <= reg_wdata[3:0];
      end
   end

   // event lines leave the block from flops, one cycle after the flag
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_ht <= 5'h00;
         irq_tc <= 5'h00;
         irq_te <= 5'h00;
      end else begin
         irq_ht <= ht_v;
         irq_tc <= tc_v;
         irq_te <= te_v;
      end
   end

   // read mux
   logic [31:0] rd_mux, ch_rd;
   logic [19:0] stat_v;
   always_comb begin
      for (int i = 0; i < N; i++) begin
         stat_v[4*i +: 4] = flag_reg[i];
      end
      ch_rd = 32'h0;
      if (|ch_hit) begin
         case (sub)
            dmr_pkg::OFS_CFG[3:0]:   ch_rd = {8'h00, cfg_reg[ch_idx]};
            dmr_pkg::OFS_CNT[3:0]:   ch_rd = {16'h0000, cnt_reg[ch_idx]};
            dmr_pkg::OFS_PADDR[3:0]: ch_rd = pptr_reg[ch_idx];
            dmr_pkg::OFS_MADDR[3:0]: ch_rd = mptr_reg[ch_idx];
            default:                 ch_rd = 32'h0;
         endcase
      end
      if (reg_addr == dmr_pkg::OFS_STATUS) begin
         rd_mux = {12'h000, stat_v};
      end else if (reg_addr == dmr_pkg::OFS_REMAP) begin
         rd_mux = {28'h0, remap_reg};
      end else if (reg_addr[7:4] != 4'h0) begin
         rd_mux = ch_rd;
      end else begin
         rd_mux = 32'h0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h0;
      end
   end
endmodule // dmr_top

// *** dmr_chk.sv ***
// checker of bus cadence, acknowledge and event line behaviour
`timescale 1ns/1ps
module dmr_chk (
   input wire logic        sys_clk,   // clock
   input wire logic        sys_rst,   // reset
   input wire logic        reg_wr,    // write strobe
   input wire logic        reg_rd,    // read strobe
   input wire logic [31:0] reg_rdata, // read data
   input wire logic [4:0]  req_ack,   // acknowledges
   input wire logic        bus_rd,    // bus read
   input wire logic        bus_wr,    // bus write
   input wire logic        bus_err,   // bus error
   input wire logic [4:0]  irq_ht,    // half lines
   input wire logic [4:0]  irq_tc     // complete lines
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_rd_then_wr: assert property (bus_rd |=> $past(bus_err) || (bus_wr && !bus_rd))
      else $error("no write after read");
   a_rd_wr_excl: assert property (!(bus_rd && bus_wr))
      else $error("read and write together");
   a_ack_after_wr: assert property (|req_ack |-> $past(bus_wr))
      else $error("ack without write");
   a_ack_onehot: assert property ($onehot0(req_ack))
      else $error("two channels acked");
   a_wr_gap: assert property (bus_wr |=> !bus_rd [*3])
      else $error("next read too early");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   // software set and enable writes may raise a line as well as a finished item
   a_tc_rise: assert property (|(irq_tc & ~$past(irq_tc)) |->
      $past(bus_wr) || $past(bus_wr, 2) || $past(bus_wr, 3) || $past(reg_wr, 2))
      else $error("complete line rose without cause");
   a_ht_rise: assert property (|(irq_ht & ~$past(irq_ht)) |->
      $past(bus_wr) || $past(bus_wr, 2) || $past(bus_wr, 3) || $past(reg_wr, 2))
      else $error("half line rose without cause");
   a_tc_fall: assert property (|($past(irq_tc) & ~irq_tc) |-> $past(reg_wr, 2))
      else $error("complete line fell without write");
   cover property (bus_err);
   cover property (|req_ack);
   cover property (|irq_tc);
endmodule // dmr_chk
bind dmr_top dmr_chk i_chk (.*);

// *** dmr_mem_model.sv ***
// memory bus partner: answers within the strobe cycle, errors where address bits 31:28 are E
`timescale 1ns/1ps
module dmr_mem_model (
   input  wire logic        sys_clk,   // clock
   input  wire logic [31:0] bus_addr,  // address
   input  wire logic        bus_rd,    // read strobe
   input  wire logic        bus_wr,    // write strobe
   output logic      [31:0] bus_rdata, // read data
   output logic             bus_err    // error
);
   // the engine samples data and error in the strobe cycle itself
   // outside a read the data show the bare address, so stale values never match
   assign bus_rdata = bus_rd ? ~bus_addr : bus_addr;
   assign bus_err   = (bus_rd | bus_wr) & (bus_addr[31:28] == 4'hE);
endmodule // dmr_mem_model

// *** dmr_top_tb.sv ***
// testbench of the five-channel transfer controller
`timescale 1ns/1ps
module dmr_top_tb;
   logic        sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, bus_rd, bus_wr, bus_err;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, bus_addr, bus_wdata, bus_rdata, wa, wd;
   logic [16:0] pin = 17'h0;
   logic [4:0]  req_ack, irq_ht, irq_tc, irq_te, m;
   int          mismatches = 0, num_checks = 0, n;
   dmr_top i_dmr_top (.*, .serial_unit_a_receive_request(pin[0]),
      .serial_unit_a_transmit_request(pin[1]), .serial_unit_b_receive_request(pin[2]),
      .serial_unit_b_transmit_request(pin[3]), .two_wire_unit_a_transmit_request(pin[4]),
      .two_wire_unit_a_receive_request(pin[5]), .two_wire_unit_b_transmit_request(pin[6]),
      .two_wire_unit_b_receive_request(pin[7]), .tmr_req(pin[11:8]), .conv_req(pin[12]),
      .uart_tx_req(pin[13]), .uart_rx_req(pin[14]), .tmr16_req(pin[15]), .tmr17_req(pin[16]));
   dmr_mem_model i_dmr_mem_model (.*);
   initial forever #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (bus_wr) {wa, wd} <= {bus_addr, bus_wdata};
   task tally_and_finish;
      if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk) reg_rd <= 1'b0;
      @(negedge sys_clk) chk(reg_rdata, e);
   endtask
   task cfg(input logic [7:0] b, input logic [23:0] v, input logic [31:0] cnt, pa);
      wr(b, 32'h0);
      wr(b + 8'h4, cnt);
      wr(b + 8'h8, pa);
      wr(b + 8'hC, 32'h2000);
      wr(b, {8'h0, v});
   endtask
   // requester holds its line until acknowledged, then drops it at the next edge
   task go(input logic [16:0] msk);
      @(posedge sys_clk) pin <= pin | msk;
   endtask
   task ack(input logic [16:0] msk, input logic [4:0] e);
      @(negedge sys_clk);
      for (int i = 0; i < 60 && req_ack == 5'h0; i++) @(negedge sys_clk);
      chk({27'h0, req_ack}, {27'h0, e});
      @(posedge sys_clk) pin <= pin & ~msk;
   endtask
   initial begin
      #400000 mismatches++;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'hFC, 32'h0);
      wr(8'h10, 32'hE);
      wr(8'h08, 32'hE);
      rd(8'h00, 32'hF);
      chk({irq_ht, irq_tc, irq_te}, 15'h0421);
      wr(8'h04, 32'hFFFFF);
      rd(8'h00, 32'h0);
      for (int p = 0; p < 8; p++) begin
         n = (p == 0) ? 3 : 2;
         m = 5'h1 << (1 + p % 4);
         cfg(8'h20 + 8'h10 * (p % 4), 24'h87 | ((p / 4) << 16) | (p == 0 ? 24'h20 : 24'h0),
            2, 32'h1000);
         for (int k = 0; k < n; k++) begin
            go(17'h1 << p);
            ack(17'h1 << p, m);
            chk(wa, 32'h2000 + 4 * (k % 2));
            chk(wd, ~32'h1000);
            repeat (2) @(negedge sys_clk);
            chk({irq_ht, irq_tc}, {m, (k > 0) ? m : 5'h0});
         end
         rd(8'h24 + 8'h10 * (p % 4), (p == 0) ? 32'h1 : 32'h0);
         wr(8'h04, 32'hFFFFF);
      end
      cfg(8'h20, 24'h87, 1, 32'h1000);
      cfg(8'h30, 24'h87, 1, 32'h1000);
      go(17'h3);
      ack(17'h1, 5'h02);
      ack(17'h2, 5'h04);
      cfg(8'h20, 24'h87, 1, 32'h1000);
      cfg(8'h30, 24'h3087, 1, 32'h1000);
      go(17'h3);
      ack(17'h2, 5'h04);
      ack(17'h1, 5'h02);
      cfg(8'h40, 24'h89, 1, 32'hE0000000);
      go(17'h4);
      repeat (30) @(negedge sys_clk);
      chk({27'h0, irq_te}, 32'h8);
      rd(8'h40, 32'h88);
      @(posedge sys_clk) pin <= 17'h0;
      cfg(8'h10, 24'h030087, 1, 32'h1000);
      go(17'h1000);
      ack(17'h1000, 5'h01);
      wr(8'h0C, 32'h1);
      cfg(8'h20, 24'h030087, 1, 32'h1000);
      go(17'h1000);
      ack(17'h1000, 5'h02);
      wr(8'h04, 32'hFFFFF);
      cfg(8'h50, 24'h4097, 2, 32'h1000);
      repeat (30) @(negedge sys_clk);
      chk(wa, 32'h1000);
      chk(wd, ~32'h2004);
      chk({27'h0, irq_tc}, 32'h10);
      tally_and_finish;
   end
endmodule // dmr_top_tb
